//--- include/ucr_defs.svh
// offsets, field positions and reset values of the uart control block
`ifndef UCR_DEFS_SVH
`define UCR_DEFS_SVH
`define UCR_OFF_STATUS 3'h2
`define UCR_OFF_CONTROL 3'h3
`define UCR_OFF_DIVISOR 3'h4
`define UCR_OFF_EOP 3'h5
`define UCR_CTRL_W 13
`define UCR_DIV_W 16
`define UCR_CHAR_W 8
`define UCR_DATA_W 16
`define UCR_BIT_PE 0
`define UCR_BIT_FE 1
`define UCR_BIT_BRK 2
`define UCR_BIT_ROE 3
`define UCR_BIT_TOE 4
`define UCR_BIT_TMT 5
`define UCR_BIT_TRDY 6
`define UCR_BIT_RRDY 7
`define UCR_BIT_EXC 8
`define UCR_BIT_BREAK 9
`define UCR_BIT_DCTS 10
`define UCR_BIT_RTS 11
`define UCR_BIT_EOP 12
`define UCR_CTRL_RST 13'h0000
`define UCR_EOP_RST 8'h00
`define UCR_DIV_RST 16'h01B1
`endif

//--- include/ucr_pkg.sv
// types of the uart control block
package ucr_pkg;
    typedef logic [12:0] ucr_ctrl_t;
    typedef logic [15:0] ucr_div_t;
    typedef logic [7:0] ucr_char_t;
    typedef struct packed {
        ucr_ctrl_t ctrl;
        ucr_div_t div;
        ucr_char_t eop_char;
        logic eop_flag;
        logic [15:0] rdata;
        logic irq;
        logic txd;
        logic rts_n;
        logic exc;
    } ucr_state_t;
    typedef struct packed {
        ucr_div_t count;
        logic tick;
    } ucr_baud_state_t;
endpackage

//--- verilog/ucr_baud_gen.sv
// baud tick generator: one tick every divisor plus one clocks
`timescale 1ns/1ps
`include "ucr_defs.svh"
module ucr_baud_gen
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // divisor
    input wire logic [15:0] divisor_in,
    // tick
    output logic tick_out
);
    ucr_pkg::ucr_baud_state_t state_reg;
    ucr_pkg::ucr_baud_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (state_reg.count >= divisor_in) // see R11
        begin
            state_next.count = 16'h0000;
            state_next.tick = 1'b1;
        end
        else
        begin
            state_next.count = state_reg.count + 16'h0001;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign tick_out = state_reg.tick;
endmodule

//--- verilog/ucr_regs.sv
// uart control, divisor and end-of-packet registers with irq, break and rts
//
// What this block does
// R1 - control register reads back its current contents at any time
// R2 - irq raised when any status flag and its enable are both one
// R3 - error enables: parity 0, framing 1, break 2, rx overrun 3, tx overrun 4
// R4 - readiness enables: tx shift empty 5, tx holding ready 6, rx ready 7
// R5 - exception enable bit 8, cts change enable bit 10, packet end bit 12
// R6 - break bit 9 forces serial output low, overriding transmitter
// R7 - software clears the break bit after the break period; device never does
// R8 - active-low rts output is inverse of control bit 11
// R9 - rts bit writable any time, affects only the rts output
// R10 - without flow control, rts bit reads zero and ignores writes
// R11 - baud rate equals clock divided by divisor plus one
// R12 - without software baud option, divisor writes ignored, reads undefined
// R13 - end-of-packet character register sets the packet terminator
// R14 - end-of-packet character resets to zero
// R15 - without end-of-packet option, writes ignored, reads undefined
// R16 - packet-end flag set when terminator written to tx or read from rx
// R17 - exception flag is or of overrun, break, framing and parity flags
// R18 - all interrupt enables clear on reset
// R19 - control bits above 12 read zero, writes ignored
`timescale 1ns/1ps
`include "ucr_defs.svh"
module ucr_regs
#(
    parameter bit FLOW_CTRL_EN = 1'b1,
    parameter bit SOFT_BAUD_EN = 1'b1,
    parameter bit EOP_REG_EN = 1'b1
)
(
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    // register port
    input wire logic [2:0] ADDRESS_IN,
    input wire logic CHIPSELECT_IN,
    input wire logic READ_IN,
    input wire logic WRITE_IN,
    input wire logic [15:0] WRITEDATA_IN,
    output logic [15:0] READDATA_OUT,
    // status flags from the uart datapath
    input wire logic PARITY_ERR_FLAG_IN,
    input wire logic FRAMING_ERR_FLAG_IN,
    input wire logic BREAK_DETECTED_FLAG_IN,
    input wire logic RX_OVERRUN_FLAG_IN,
    input wire logic TX_OVERRUN_FLAG_IN,
    input wire logic TX_SHIFT_EMPTY_IN,
    input wire logic TX_HOLDING_READY_IN,
    input wire logic RX_CHAR_READY_IN,
    input wire logic CTS_CHANGE_FLAG_IN,
    // character traffic for packet-end detection
    input wire logic TX_CHAR_WRITE_IN,
    input wire logic [7:0] TX_CHAR_IN,
    input wire logic RX_CHAR_READ_IN,
    input wire logic [7:0] RX_CHAR_IN,
    // transmitter level
    input wire logic TX_SERIAL_IN,
    // serial side and results
    output logic TXD_OUT,
    output logic RTS_N_OUT,
    output logic IRQ_OUT,
    output logic EXCEPTION_FLAG_OUT,
    output logic PACKET_END_FLAG_OUT,
    output logic [7:0] PACKET_END_CHAR_OUT,
    output logic BAUD_TICK_OUT
);
    ucr_pkg::ucr_state_t state_reg;
    ucr_pkg::ucr_state_t state_next;
    logic exc_next;
    logic [12:0] status_flags;
    logic [12:0] ctrl_mask;
    logic wr_en;
    logic rd_en;
    logic eop_hit;
    logic [15:0] div_used;

    assign wr_en = CHIPSELECT_IN & WRITE_IN;
    assign rd_en = CHIPSELECT_IN & READ_IN;

    always_comb
    begin
        ctrl_mask = 13'h1FFF;
        ctrl_mask[`UCR_BIT_RTS] = FLOW_CTRL_EN; // see R10
    end

    always_comb
    begin
        exc_next = PARITY_ERR_FLAG_IN | FRAMING_ERR_FLAG_IN | BREAK_DETECTED_FLAG_IN
            | RX_OVERRUN_FLAG_IN | TX_OVERRUN_FLAG_IN; // see R17
        status_flags = 13'h0000;
        status_flags[`UCR_BIT_PE] = PARITY_ERR_FLAG_IN;
        status_flags[`UCR_BIT_FE] = FRAMING_ERR_FLAG_IN;
        status_flags[`UCR_BIT_BRK] = BREAK_DETECTED_FLAG_IN;
        status_flags[`UCR_BIT_ROE] = RX_OVERRUN_FLAG_IN;
        status_flags[`UCR_BIT_TOE] = TX_OVERRUN_FLAG_IN;
        status_flags[`UCR_BIT_TMT] = TX_SHIFT_EMPTY_IN;
        status_flags[`UCR_BIT_TRDY] = TX_HOLDING_READY_IN;
        status_flags[`UCR_BIT_RRDY] = RX_CHAR_READY_IN;
        status_flags[`UCR_BIT_EXC] = exc_next;
        status_flags[`UCR_BIT_DCTS] = CTS_CHANGE_FLAG_IN & FLOW_CTRL_EN;
        status_flags[`UCR_BIT_EOP] = state_reg.eop_flag;
    end

    assign eop_hit = EOP_REG_EN
        & ((TX_CHAR_WRITE_IN & (TX_CHAR_IN == state_reg.eop_char))
        | (RX_CHAR_READ_IN & (RX_CHAR_IN == state_reg.eop_char))); // see R13 R16

    always_comb
    begin
        state_next = state_reg;
        // register writes
        if (wr_en)
        begin
            case (ADDRESS_IN)
                `UCR_OFF_CONTROL:
                begin
                    state_next.ctrl = WRITEDATA_IN[12:0] & ctrl_mask; // see R3 R4 R5 R9 R10 R19
                end
                `UCR_OFF_DIVISOR:
                begin
                    if (SOFT_BAUD_EN) // see R12
                    begin
                        state_next.div = WRITEDATA_IN;
                    end
                end
                `UCR_OFF_EOP:
                begin
                    if (EOP_REG_EN) // see R15
                    begin
                        state_next.eop_char = WRITEDATA_IN[7:0];
                    end
                end
                `UCR_OFF_STATUS:
                begin
                    state_next.eop_flag = 1'b0;
                end
                default:
                begin
                    state_next.ctrl = state_reg.ctrl;
                end
            endcase
        end
        // set wins over status-write clear
        if (eop_hit)
        begin
            state_next.eop_flag = 1'b1; // see R16
        end
        // registered read data
        state_next.rdata = 16'h0000;
        if (rd_en)
        begin
            case (ADDRESS_IN)
                `UCR_OFF_CONTROL:
                begin
                    state_next.rdata = {3'h0, state_reg.ctrl}; // see R1 R19
                end
                `UCR_OFF_DIVISOR:
                begin
                    state_next.rdata = SOFT_BAUD_EN ? state_reg.div : 16'h0000; // see R12
                end
                `UCR_OFF_EOP:
                begin
                    state_next.rdata = EOP_REG_EN ? {8'h00, state_reg.eop_char} : 16'h0000; // see R15
                end
                default:
                begin
                    state_next.rdata = 16'h0000;
                end
            endcase
        end
        state_next.irq = |(status_flags & state_reg.ctrl & 13'h15FF); // see R2
        state_next.txd = state_reg.ctrl[`UCR_BIT_BREAK] ? 1'b0 : TX_SERIAL_IN; // see R6 R7
        state_next.rts_n = ~state_reg.ctrl[`UCR_BIT_RTS]; // see R8 R9
        state_next.exc = exc_next; // see R17
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            state_reg.ctrl <= `UCR_CTRL_RST; // see R18
            state_reg.div <= `UCR_DIV_RST;
            state_reg.eop_char <= `UCR_EOP_RST; // see R14
            state_reg.eop_flag <= 1'b0;
            state_reg.rdata <= 16'h0000;
            state_reg.irq <= 1'b0;
            state_reg.txd <= 1'b1;
            state_reg.rts_n <= 1'b1;
            state_reg.exc <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign div_used = SOFT_BAUD_EN ? state_reg.div : `UCR_DIV_RST;

    ucr_baud_gen u_baud
    (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN),
        .divisor_in(div_used),
        .tick_out(BAUD_TICK_OUT)
    );

    assign READDATA_OUT = state_reg.rdata;
    assign TXD_OUT = state_reg.txd;
    assign RTS_N_OUT = state_reg.rts_n;
    assign IRQ_OUT = state_reg.irq;
    assign EXCEPTION_FLAG_OUT = state_reg.exc;
    assign PACKET_END_FLAG_OUT = state_reg.eop_flag;
    assign PACKET_END_CHAR_OUT = state_reg.eop_char;
endmodule

//--- sim/ucr_regs_sva.sv
// assertion checker for the uart control registers
`timescale 1ns/1ps
module ucr_regs_sva
(
    // watched ports
    input wire logic REF_CLK_IN, RST_N_IN, CHIPSELECT_IN, READ_IN, WRITE_IN, TX_SERIAL_IN,
    input wire logic [2:0] ADDRESS_IN,
    input wire logic [15:0] WRITEDATA_IN, READDATA_OUT,
    input wire logic TX_CHAR_WRITE_IN, RX_CHAR_READ_IN, TXD_OUT, RTS_N_OUT, IRQ_OUT, PACKET_END_FLAG_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    wire cw = CHIPSELECT_IN && WRITE_IN && ADDRESS_IN == 3'h3;
    wire ce = TX_CHAR_WRITE_IN || RX_CHAR_READ_IN;
    AST_RTS: assert property (cw |-> ##2 RTS_N_OUT == !$past(WRITEDATA_IN[11], 2)) else $error("rts level");
    AST_RTC: assert property ($changed(RTS_N_OUT) |-> $past(cw, 2)) else $error("rts moved");
    AST_BRK: assert property (cw && WRITEDATA_IN[9] |-> ##2 !TXD_OUT) else $error("break");
    AST_TXD: assert property (TXD_OUT && $past(RST_N_IN) |-> $past(TX_SERIAL_IN)) else $error("txd");
    AST_IRQ: assert property (cw && WRITEDATA_IN[12:0] == 13'h0000 |-> ##2 !IRQ_OUT) else $error("irq");
    AST_RD: assert property (READDATA_OUT != 16'h0000 |-> $past(CHIPSELECT_IN && READ_IN)) else $error("rd");
    AST_HI: assert property (CHIPSELECT_IN && READ_IN && ADDRESS_IN == 3'h3 |=> READDATA_OUT[15:13] == 3'h0)
        else $error("high bits");
    AST_PE: assert property ($rose(PACKET_END_FLAG_OUT) |-> $past(ce)) else $error("eop flag");
endmodule
bind ucr_regs ucr_regs_sva i_ucr_regs_sva (.*);

//--- sim/ucr_far_model.sv
// remote serial device watching the txd line
`timescale 1ns/1ps
module ucr_far_model
(
    // line in, break length out
    input wire logic clk_in, txd_in,
    output int low_run_out = 0
);
    // clocks the line has stayed low
    always @(posedge clk_in)
    begin
        low_run_out <= txd_in ? 0 : low_run_out + 1;
    end
endmodule

//--- sim/ucr_regs_tb_top.sv
// testbench for the uart control registers
`timescale 1ns/1ps
module ucr_regs_tb_top;
    logic clk = 0, rst_n = 0, cs = 0, rd = 0, wr = 0, txw = 0, rxr = 0, ser = 1;
    logic [2:0] adr = 0;
    logic [15:0] wd = 0, rdat, d, v;
    logic [8:0] fl = 0;
    logic [7:0] ch = 0, pch;
    logic txd, rts_n, irq, exc, pef, tick;
    int err_total = 0, num_checks = 0, seed = 13, low, n;
    always #10 clk = ~clk;
    ucr_regs i_ucr_regs (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .ADDRESS_IN(adr), .CHIPSELECT_IN(cs), .READ_IN(rd),
        .WRITE_IN(wr), .WRITEDATA_IN(wd), .READDATA_OUT(rdat), .PARITY_ERR_FLAG_IN(fl[0]),
        .FRAMING_ERR_FLAG_IN(fl[1]), .BREAK_DETECTED_FLAG_IN(fl[2]), .RX_OVERRUN_FLAG_IN(fl[3]),
        .TX_OVERRUN_FLAG_IN(fl[4]), .TX_SHIFT_EMPTY_IN(fl[5]), .TX_HOLDING_READY_IN(fl[6]),
        .RX_CHAR_READY_IN(fl[7]), .CTS_CHANGE_FLAG_IN(fl[8]), .TX_CHAR_WRITE_IN(txw), .TX_CHAR_IN(ch),
        .RX_CHAR_READ_IN(rxr), .RX_CHAR_IN(ch), .TX_SERIAL_IN(ser), .TXD_OUT(txd), .RTS_N_OUT(rts_n),
        .IRQ_OUT(irq), .EXCEPTION_FLAG_OUT(exc), .PACKET_END_FLAG_OUT(pef), .PACKET_END_CHAR_OUT(pch),
        .BAUD_TICK_OUT(tick));
    ucr_far_model i_ucr_far_model (.clk_in(clk), .txd_in(txd), .low_run_out(low));
    task automatic chk(input string nm, input logic [15:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] dat);
        @(negedge clk);
        {cs, wr, rd, adr, wd} = {1'b1, w, !w, a, dat};
        @(negedge clk);
        {cs, wr, rd} = '0;
        v = rdat;
    endtask
    task automatic ev(input logic t, input logic [7:0] c);
        @(negedge clk);
        {txw, rxr, ch} = {t, !t, c};
        @(negedge clk);
        {txw, rxr} = '0;
    endtask
    function automatic logic irq_f(input logic [12:0] c, input logic [8:0] f);
        return |(c & {2'b00, f[8], 1'b0, |f[4:0], f[7:0]});
    endfunction
    task automatic print_verdict;
        if (err_total == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #400000;
        err_total++;
        print_verdict;
    end
    initial
    begin
        repeat (16) @(negedge clk);
        rst_n = 1;
        bus(0, 3'h3, '0);
        chk("ctrl rst", v, '0);
        bus(0, 3'h5, '0);
        chk("eop rst", {pch, v[7:0]}, '0);
        for (int i = 0; i < 40; i++)
        begin
            {d, fl, ser} = {16'($random(seed)), 9'($random(seed)), 1'($random(seed))};
            if (i < 14)
                {d, fl} = {16'h0001 << i, 9'h1ff};
            bus(1, 3'h3, d);
            bus(0, 3'h3, '0);
            chk("ctrl", v, d & 16'h1fff);
            chk("rts_n", rts_n, !d[11]);
            chk("irq", irq, irq_f(d[12:0], fl));
            chk("exc", exc, |fl[4:0]);
        end
        ser = 1;
        bus(1, 3'h3, 16'h0200);
        repeat (20) @(negedge clk);
        chk("brk", {txd, low > 18}, 2'b01);
        bus(1, 3'h3, '0);
        bus(0, 3'h3, '0);
        chk("txd", txd, 1'b1);
        bus(1, 3'h4, 16'h0005);
        for (n = 0; !tick && n < 600; n++) @(negedge clk);
        @(negedge clk);
        for (n = 1; !tick && n < 9; n++) @(negedge clk);
        chk("baud", 16'(n), 16'h0006);
        d = 16'($random(seed));
        bus(1, 3'h5, d);
        ev(1, ~d[7:0]);
        chk("eop chr", {pef, pch}, {1'b0, d[7:0]});
        ev(0, d[7:0]);
        chk("eop rx", pef, 1'b1);
        bus(1, 3'h2, '0);
        chk("eop clr", pef, 1'b0);
        ev(1, d[7:0]);
        bus(1, 3'h3, 16'h1000);
        bus(0, 3'h5, '0);
        chk("eop irq", {pef, irq, v[7:0]}, {2'b11, d[7:0]});
        print_verdict;
    end
endmodule
